// [rtl/ifpcn_pkg.sv]
// Purpose: constants and types of the interrupt flag, priority and change-notify block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register, 16-bit data
// Notes: change-notify words hold 16 pins each, six words cover 84 pins
package ifpcn_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // register byte offsets
    localparam logic [7:0] OFS_FLAG_STATUS_TWO = 8'h00;
    localparam logic [7:0] OFS_PRIO_ADC_UART_TX = 8'h04;
    localparam logic [7:0] OFS_PRIO_SERIAL_TWO = 8'h08;
    localparam logic [7:0] OFS_CN_ENABLE0 = 8'h10;
    localparam logic [7:0] OFS_CN_PULLUP0 = 8'h30;
    localparam logic [7:0] OFS_CN_PULLDOWN0 = 8'h50;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h74;
    localparam logic [7:0] OFS_CN_CONTROL = 8'h78;
    localparam logic [7:0] WORD_STRIDE = 8'h04;
    // change-notify geometry
    localparam int CN_PINS = 84;
    localparam int CN_WORDS = 6;
    localparam int CN_BITS = CN_WORDS * REG_W;
    localparam int USB_DPLUS_IDX = 82;
    localparam int USB_DMINUS_IDX = 83;
    localparam int CTRL_USB_DIS = 0;
    // flag word field positions
    localparam int FLAG_SER2_FAULT = 0;
    localparam int FLAG_SER2_EVENT = 1;
    localparam int FLAG_CAP3 = 5;
    localparam logic [15:0] FLAG_IMPL_MASK = 16'h01E3;
    // priority word field positions and reset
    localparam int PRIO_HI_LSB = 4;
    localparam int PRIO_LO_LSB = 0;
    localparam logic [15:0] PRIO_IMPL_MASK = 16'h0077;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [15:0] PRIO_WORD_RESET = 16'h0044;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    // sticky event status bits
    localparam int IRQ_W = 7;
    localparam int IRQ_CN = 0;
    localparam int IRQ_SER2_EVENT = 1;
    localparam int IRQ_SER2_FAULT = 2;
    localparam int IRQ_CAP_LSB = 3;
    // bus answer phases
    typedef enum logic [1:0] {
        IFPCN_BUS_IDLE = 2'b01,
        IFPCN_BUS_ANSWER = 2'b10
    } ifpcn_bus_phase_t;
    // whole state of the block
    typedef struct packed {
        ifpcn_bus_phase_t phase;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
        logic [REG_W-1:0] flags;
        logic [REG_W-1:0] prio_adc_uart;
        logic [REG_W-1:0] prio_serial2;
        logic [CN_BITS-1:0] cn_en;
        logic [CN_BITS-1:0] cn_pu;
        logic [CN_BITS-1:0] cn_pd;
        logic [CN_PINS-1:0] cn_prev;
        logic cn_armed;
        logic usb_dis;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [2:0] pend;
        logic wake;
    } ifpcn_state_t;
endpackage

// [rtl/ifpcn_top.sv]
// Purpose: interrupt flags, priority fields and pin change notification behind Avalon-MM
// Assumes: pins and event lines are synchronous to ref_clk; event lines are one-cycle pulses
// Notes: waitrequest idles high; every access answers on the second edge
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module ifpcn_top (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ifpcn_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ifpcn_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ifpcn_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] capture_event,
    input wire logic serial2_event_req,
    input wire logic serial2_fault_req,
    input wire logic [ifpcn_pkg::CN_PINS-1:0] cn_pin,
    input wire logic sleep_mode,
    output logic irq,
    output logic [2:0] pend_priority,
    output logic cn_wake,
    output logic [ifpcn_pkg::REG_W-1:0] flag_status,
    output logic [2:0] adc_done_priority,
    output logic [2:0] uart1_transmit_priority,
    output logic [ifpcn_pkg::CN_PINS-1:0] cn_pullup_en,
    output logic [ifpcn_pkg::CN_PINS-1:0] cn_pulldown_en
);
    ifpcn_pkg::ifpcn_state_t s;
    ifpcn_pkg::ifpcn_state_t n;
    logic [ifpcn_pkg::CN_PINS-1:0] cn_enabled;
    logic [ifpcn_pkg::CN_PINS-1:0] cn_usb_gate;
    logic [ifpcn_pkg::CN_PINS-1:0] cn_change;
    logic wr_take;
    logic rd_take;

    // true when addr falls in one of the six words starting at base
    function automatic logic cn_hit(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        cn_hit = (addr >= base) && (d[1:0] == 2'b00) && (d[7:2] < 6'(ifpcn_pkg::CN_WORDS));
    endfunction

    // word index within a six-word group
    function automatic logic [2:0] cn_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        cn_idx = d[4:2];
    endfunction

    // merge the low two byte lanes of a write into a 16-bit register
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        lane_merge = old;
        if (be[0])
        begin
            lane_merge[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            lane_merge[15:8] = wdata[15:8];
        end
    endfunction

    // a field value is its priority level; zero means off
    function automatic logic [2:0] prio_level(input logic pending, input logic [2:0] field);
        prio_level = pending ? field : ifpcn_pkg::PRIO_OFF;
    endfunction

    // register read multiplexer, unmapped addresses read zero
    function automatic logic [31:0] read_word(
        input ifpcn_pkg::ifpcn_state_t st,
        input logic [7:0] addr
    );
        read_word = '0;
        if (addr == ifpcn_pkg::OFS_FLAG_STATUS_TWO)
        begin
            read_word[15:0] = st.flags & ifpcn_pkg::FLAG_IMPL_MASK;
        end
        else if (addr == ifpcn_pkg::OFS_PRIO_ADC_UART_TX)
        begin
            read_word[15:0] = st.prio_adc_uart & ifpcn_pkg::PRIO_IMPL_MASK;
        end
        else if (addr == ifpcn_pkg::OFS_PRIO_SERIAL_TWO)
        begin
            read_word[15:0] = st.prio_serial2 & ifpcn_pkg::PRIO_IMPL_MASK;
        end
        else if (cn_hit(addr, ifpcn_pkg::OFS_CN_ENABLE0))
        begin
            read_word[15:0] = st.cn_en[cn_idx(addr, ifpcn_pkg::OFS_CN_ENABLE0)*16 +: 16];
        end
        else if (cn_hit(addr, ifpcn_pkg::OFS_CN_PULLUP0))
        begin
            read_word[15:0] = st.cn_pu[cn_idx(addr, ifpcn_pkg::OFS_CN_PULLUP0)*16 +: 16];
        end
        else if (cn_hit(addr, ifpcn_pkg::OFS_CN_PULLDOWN0))
        begin
            read_word[15:0] = st.cn_pd[cn_idx(addr, ifpcn_pkg::OFS_CN_PULLDOWN0)*16 +: 16];
        end
        else if (addr == ifpcn_pkg::OFS_IRQ_STATUS)
        begin
            read_word[ifpcn_pkg::IRQ_W-1:0] = st.irq_stat;
        end
        else if (addr == ifpcn_pkg::OFS_IRQ_MASK)
        begin
            read_word[ifpcn_pkg::IRQ_W-1:0] = st.irq_mask;
        end
        else if (addr == ifpcn_pkg::OFS_CN_CONTROL)
        begin
            read_word[ifpcn_pkg::CTRL_USB_DIS] = st.usb_dis;
        end
    endfunction

    // per-pin enable and usb gating, one slice per pin
    genvar gi;
    generate
        for (gi = 0; gi < ifpcn_pkg::CN_PINS; gi++)
        begin : g_pin
            assign cn_enabled[gi] = s.cn_en[gi];
            assign cn_usb_gate[gi] = ((gi == ifpcn_pkg::USB_DPLUS_IDX)
                || (gi == ifpcn_pkg::USB_DMINUS_IDX)) ? s.usb_dis : 1'b1;
            assign cn_change[gi] = s.cn_armed && (cn_pin[gi] ^ s.cn_prev[gi])
                && cn_enabled[gi] && cn_usb_gate[gi];
        end
    endgenerate

    // accesses take effect only on the edge where waitrequest is low
    assign wr_take = avs_write && (s.phase == ifpcn_pkg::IFPCN_BUS_ANSWER);
    assign rd_take = avs_read && (s.phase == ifpcn_pkg::IFPCN_BUS_ANSWER);

    // next-state logic for the whole block
    always_comb
    begin
        logic [ifpcn_pkg::IRQ_W-1:0] ev;
        logic [15:0] hw_set;
        logic [2:0] lvl_evt;
        logic [2:0] lvl_flt;
        ev = '0;
        hw_set = '0;
        lvl_evt = '0;
        lvl_flt = '0;
        n = s;
        // bus answer sequencing
        unique case (s.phase)
            ifpcn_pkg::IFPCN_BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    n.phase = ifpcn_pkg::IFPCN_BUS_ANSWER;
                    n.waitreq = 1'b0;
                    n.rdata = avs_read ? read_word(s, avs_address) : '0;
                end
            end
            ifpcn_pkg::IFPCN_BUS_ANSWER:
            begin
                n.phase = ifpcn_pkg::IFPCN_BUS_IDLE;
                n.waitreq = 1'b1;
            end
        endcase
        // register writes; flag and priority words drop unimplemented bits, change-notify words keep all 16
        if (wr_take)
        begin
            if (avs_address == ifpcn_pkg::OFS_FLAG_STATUS_TWO)
            begin
                n.flags = lane_merge(s.flags, avs_writedata, avs_byteenable)
                    & ifpcn_pkg::FLAG_IMPL_MASK;
            end
            if (avs_address == ifpcn_pkg::OFS_PRIO_ADC_UART_TX)
            begin
                n.prio_adc_uart = lane_merge(s.prio_adc_uart, avs_writedata, avs_byteenable)
                    & ifpcn_pkg::PRIO_IMPL_MASK;
            end
            if (avs_address == ifpcn_pkg::OFS_PRIO_SERIAL_TWO)
            begin
                n.prio_serial2 = lane_merge(s.prio_serial2, avs_writedata, avs_byteenable)
                    & ifpcn_pkg::PRIO_IMPL_MASK;
            end
            if (cn_hit(avs_address, ifpcn_pkg::OFS_CN_ENABLE0))
            begin
                n.cn_en[cn_idx(avs_address, ifpcn_pkg::OFS_CN_ENABLE0)*16 +: 16] = lane_merge(
                    s.cn_en[cn_idx(avs_address, ifpcn_pkg::OFS_CN_ENABLE0)*16 +: 16],
                    avs_writedata, avs_byteenable);
            end
            if (cn_hit(avs_address, ifpcn_pkg::OFS_CN_PULLUP0))
            begin
                n.cn_pu[cn_idx(avs_address, ifpcn_pkg::OFS_CN_PULLUP0)*16 +: 16] = lane_merge(
                    s.cn_pu[cn_idx(avs_address, ifpcn_pkg::OFS_CN_PULLUP0)*16 +: 16],
                    avs_writedata, avs_byteenable);
            end
            if (cn_hit(avs_address, ifpcn_pkg::OFS_CN_PULLDOWN0))
            begin
                n.cn_pd[cn_idx(avs_address, ifpcn_pkg::OFS_CN_PULLDOWN0)*16 +: 16] = lane_merge(
                    s.cn_pd[cn_idx(avs_address, ifpcn_pkg::OFS_CN_PULLDOWN0)*16 +: 16],
                    avs_writedata, avs_byteenable);
            end
            if ((avs_address == ifpcn_pkg::OFS_IRQ_MASK) && avs_byteenable[0])
            begin
                n.irq_mask = avs_writedata[ifpcn_pkg::IRQ_W-1:0];
            end
            if ((avs_address == ifpcn_pkg::OFS_CN_CONTROL) && avs_byteenable[0])
            begin
                n.usb_dis = avs_writedata[ifpcn_pkg::CTRL_USB_DIS];
            end
        end
        // hardware flag sets win over a same-cycle software clear
        hw_set[ifpcn_pkg::FLAG_SER2_FAULT] = serial2_fault_req;
        hw_set[ifpcn_pkg::FLAG_SER2_EVENT] = serial2_event_req;
        hw_set[ifpcn_pkg::FLAG_CAP3 +: 4] = capture_event;
        n.flags = n.flags | hw_set;
        // pin change tracking; first cycle after reset only samples
        n.cn_prev = cn_pin;
        n.cn_armed = 1'b1;
        n.wake = sleep_mode && (|cn_change);
        // sticky events: read clears only the bits returned
        if (rd_take && (avs_address == ifpcn_pkg::OFS_IRQ_STATUS))
        begin
            n.irq_stat = s.irq_stat & ~s.rdata[ifpcn_pkg::IRQ_W-1:0];
        end
        ev[ifpcn_pkg::IRQ_CN] = |cn_change;
        ev[ifpcn_pkg::IRQ_SER2_EVENT] = serial2_event_req
            && (s.prio_serial2[ifpcn_pkg::PRIO_HI_LSB +: 3] != ifpcn_pkg::PRIO_OFF);
        ev[ifpcn_pkg::IRQ_SER2_FAULT] = serial2_fault_req
            && (s.prio_serial2[ifpcn_pkg::PRIO_LO_LSB +: 3] != ifpcn_pkg::PRIO_OFF);
        ev[ifpcn_pkg::IRQ_CAP_LSB +: 4] = capture_event;
        n.irq_stat = n.irq_stat | ev;
        n.irq = |(n.irq_stat & n.irq_mask);
        // highest enabled pending level of the serial2 pair
        lvl_evt = prio_level(n.flags[ifpcn_pkg::FLAG_SER2_EVENT],
            n.prio_serial2[ifpcn_pkg::PRIO_HI_LSB +: 3]);
        lvl_flt = prio_level(n.flags[ifpcn_pkg::FLAG_SER2_FAULT],
            n.prio_serial2[ifpcn_pkg::PRIO_LO_LSB +: 3]);
        n.pend = (lvl_evt > lvl_flt) ? lvl_evt : lvl_flt;
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s <= '0;
            s.phase <= ifpcn_pkg::IFPCN_BUS_IDLE;
            s.waitreq <= 1'b1;
            s.prio_adc_uart <= ifpcn_pkg::PRIO_WORD_RESET;
            s.prio_serial2 <= ifpcn_pkg::PRIO_WORD_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    // outputs straight from state flops
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign irq = s.irq;
    assign pend_priority = s.pend;
    assign cn_wake = s.wake;
    assign flag_status = s.flags;
    assign adc_done_priority = s.prio_adc_uart[ifpcn_pkg::PRIO_HI_LSB +: 3];
    assign uart1_transmit_priority = s.prio_adc_uart[ifpcn_pkg::PRIO_LO_LSB +: 3];
    assign cn_pullup_en = s.cn_pu[ifpcn_pkg::CN_PINS-1:0];
    assign cn_pulldown_en = s.cn_pd[ifpcn_pkg::CN_PINS-1:0];

    // checks on the block's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    property p_cap_flag;
        capture_event[3] |=> s.flags[8] ##1 (s.flags[8] || $past(wr_take));
    endproperty
    a_cap_flag: assert property (p_cap_flag) else $error("capture6 flag not set");

    property p_cap3_flag;
        capture_event[0] |=> s.flags[5];
    endproperty
    a_cap3_flag: assert property (p_cap3_flag) else $error("capture3 flag not set");

    property p_ser2_pos;
        serial2_event_req && !serial2_fault_req && !wr_take
            |=> s.flags[1] && ($past(s.flags[0]) == s.flags[0]);
    endproperty
    a_ser2_pos: assert property (p_ser2_pos) else $error("serial2 event flag misplaced");

    property p_unimpl_zero;
        ((s.flags & ~ifpcn_pkg::FLAG_IMPL_MASK) == 16'h0000)
            && ((s.prio_serial2 & ~ifpcn_pkg::PRIO_IMPL_MASK) == 16'h0000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_prio_reset;
        $fell(srst) |-> (s.prio_serial2 == 16'h0044) && (s.prio_adc_uart == 16'h0044);
    endproperty
    a_prio_reset: assert property (p_prio_reset) else $error("priority reset not 100");

    property p_flag_sticky;
        s.flags[1] && !(wr_take && (avs_address == ifpcn_pkg::OFS_FLAG_STATUS_TWO))
            |=> s.flags[1];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped itself");

    property p_disabled_silent;
        (s.prio_serial2 == 16'h0000) && $stable(s.prio_serial2) |-> (s.pend == 3'h0);
    endproperty
    a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source level");

    property p_level_linear;
        s.flags[1] && !s.flags[0] && $stable(s.flags) && $stable(s.prio_serial2)
            |-> (s.pend == s.prio_serial2[6:4]);
    endproperty
    a_level_linear: assert property (p_level_linear) else $error("level not field value");

    property p_cn_raise;
        (|cn_change) |=> s.irq_stat[ifpcn_pkg::IRQ_CN];
    endproperty
    a_cn_raise: assert property (p_cn_raise) else $error("pin change not flagged");

    property p_cn_sleep;
        sleep_mode && (|cn_change) |=> cn_wake;
    endproperty
    a_cn_sleep: assert property (p_cn_sleep) else $error("no wake in sleep");

    property p_wake_cause;
        !(sleep_mode && (|cn_change)) |=> !cn_wake;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without change");

    property p_ser2_off;
        serial2_event_req && !s.irq_stat[ifpcn_pkg::IRQ_SER2_EVENT]
            && (s.prio_serial2[ifpcn_pkg::PRIO_HI_LSB +: 3] == ifpcn_pkg::PRIO_OFF)
            |=> !s.irq_stat[ifpcn_pkg::IRQ_SER2_EVENT];
    endproperty
    a_ser2_off: assert property (p_ser2_off) else $error("disabled source set");

    property p_bus_answer;
        (avs_read || avs_write) && s.waitreq && (s.phase == ifpcn_pkg::IFPCN_BUS_IDLE)
            |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

    property p_irq_level;
        s.irq == (|(s.irq_stat & s.irq_mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not status and mask");

    c_cn_irq: cover property (|cn_change ##1 irq);
    c_sleep_wake: cover property (sleep_mode ##1 cn_wake);
    c_stat_read: cover property (rd_take && (avs_address == ifpcn_pkg::OFS_IRQ_STATUS));
    c_pend_seven: cover property (s.pend == 3'h7);
endmodule
`default_nettype wire

// [tb/ifpcn_tb.sv]
// Purpose: self-checking bench of the interrupt flag, priority and change-notify block
// Assumes: one clock, synchronous active-high reset, Avalon-MM answering after one wait
// Notes: random values from a fixed seed mixed with hand-written corner cases
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); end end
module tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [ifpcn_pkg::ADDR_W-1:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [ifpcn_pkg::DATA_W-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [ifpcn_pkg::DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] capture_event = 4'h0;
    logic serial2_event_req = 1'b0;
    logic serial2_fault_req = 1'b0;
    logic [ifpcn_pkg::CN_PINS-1:0] cn_pin = '0;
    logic sleep_mode = 1'b0;
    logic irq;
    logic [2:0] pend_priority;
    logic cn_wake;
    logic [ifpcn_pkg::REG_W-1:0] flag_status;
    logic [2:0] adc_done_priority;
    logic [2:0] uart1_transmit_priority;
    logic [ifpcn_pkg::CN_PINS-1:0] cn_pullup_en;
    logic [ifpcn_pkg::CN_PINS-1:0] cn_pulldown_en;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] rd;
    logic [15:0] r;
    logic [15:0] last;
    logic [3:0] cap;
    logic [2:0] p;
    // 125 MHz clock
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    ifpcn_top dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .capture_event(capture_event),
        .serial2_event_req(serial2_event_req), .serial2_fault_req(serial2_fault_req),
        .cn_pin(cn_pin), .sleep_mode(sleep_mode), .irq(irq), .pend_priority(pend_priority),
        .cn_wake(cn_wake), .flag_status(flag_status), .adc_done_priority(adc_done_priority),
        .uart1_transmit_priority(uart1_transmit_priority), .cn_pullup_en(cn_pullup_en),
        .cn_pulldown_en(cn_pulldown_en));
    // expected flag word from requests
    function automatic logic [15:0] flag_exp(input logic [3:0] c, input logic e,
        input logic f);
        logic [15:0] w;
        w = 16'h0000;
        w[8:5] = c;
        w[1] = e;
        w[0] = f;
        return w;
    endfunction
    // expected priority word: two 3-bit fields only
    function automatic logic [15:0] prio_exp(input logic [15:0] w);
        return {9'h000, w[6:4], 1'b0, w[2:0]};
    endfunction
    // verdict and end of run
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            i++;
        end
        while (avs_waitrequest !== 1'b0 && i < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i >= 50)
        begin
            n_errors++;
            $display("[ERR] %0t bus answer timed out", $time);
            print_verdict();
        end
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 16'h0000, 4'hF, q);
    endtask
    // one-cycle event pulses
    task automatic pulse(input logic [3:0] c, input logic e, input logic f);
        @(posedge ref_clk);
        capture_event <= c;
        serial2_event_req <= e;
        serial2_fault_req <= f;
        @(posedge ref_clk);
        capture_event <= 4'h0;
        serial2_event_req <= 1'b0;
        serial2_fault_req <= 1'b0;
    endtask
    // flip one change-notify pin
    task automatic toggle(input int k);
        @(posedge ref_clk);
        cn_pin[k] <= ~cn_pin[k];
        @(posedge ref_clk);
    endtask
    // main sequence
    initial
    begin
        void'($urandom(95));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        rd16(8'h00, rd);
        `CHK(rd, 32'h0)
        rd16(8'h04, rd);
        `CHK(rd, 32'h44)
        rd16(8'h08, rd);
        `CHK(rd, 32'h44)
        `CHK(adc_done_priority, 3'h4)
        rd16(8'hFC, rd);
        `CHK(rd, 32'h0)
        // random priority words, reserved bits dropped
        repeat (8)
        begin
            r = 16'($urandom);
            wr16(8'h08, r);
            rd16(8'h08, rd);
            `CHK(rd, {16'h0000, prio_exp(r)})
            wr16(8'h04, r);
            #1;
            `CHK(adc_done_priority, r[6:4])
            `CHK(uart1_transmit_priority, r[2:0])
            last = prio_exp(r);
        end
        bus(1'b1, 8'h04, 16'hFFFF, 4'h2, rd);
        rd16(8'h04, rd);
        `CHK(rd, {16'h0000, last})
        // random capture requests, sticky until written zero
        wr16(8'h74, 16'h007F);
        repeat (8)
        begin
            cap = 4'($urandom);
            pulse(cap, 1'b0, 1'b0);
            #1;
            `CHK(irq, |cap)
            rd16(8'h00, rd);
            `CHK(rd, {16'h0000, flag_exp(cap, 1'b0, 1'b0)})
            `CHK(flag_status, flag_exp(cap, 1'b0, 1'b0))
            wr16(8'h00, 16'h0000);
            rd16(8'h00, rd);
            `CHK(rd, 32'h0)
            rd16(8'h70, rd);
            `CHK(rd, {25'h0, cap, 3'h0})
        end
        // every priority code with fault field disabled; fault request on odd codes only
        for (int k = 0; k < 8; k++)
        begin
            p = k[2:0];
            wr16(8'h08, {9'h000, p, 4'h0});
            pulse(4'h0, 1'b1, k[0]);
            rd16(8'h00, rd);
            `CHK(rd, {16'h0000, flag_exp(4'h0, 1'b1, k[0])})
            `CHK(pend_priority, p)
            rd16(8'h70, rd);
            `CHK(rd, (p != 3'h0) ? 32'h2 : 32'h0)
            wr16(8'h00, 16'h0000);
        end
        // masked source: status sticky, no interrupt
        wr16(8'h74, 16'h0000);
        pulse(4'h1, 1'b0, 1'b0);
        #1;
        `CHK(irq, 1'b0)
        rd16(8'h70, rd);
        `CHK(rd, 32'h8)
        wr16(8'h74, 16'h007F);
        // change notify enables and pulls; every bench pin is an input, so pull-ups may stay on
        wr16(8'h10, 16'h0001);
        r = 16'($urandom);
        wr16(8'h30, r);
        wr16(8'h64, r);
        #1;
        `CHK(cn_pullup_en[15:0], r)
        `CHK(cn_pulldown_en[83:80], r[3:0])
        toggle(0);
        #1;
        `CHK(cn_wake, 1'b0)
        rd16(8'h70, rd);
        `CHK(rd, 32'h1)
        toggle(1);
        rd16(8'h70, rd);
        `CHK(rd, 32'h0)
        @(posedge ref_clk);
        sleep_mode <= 1'b1;
        toggle(0);
        #1;
        `CHK(cn_wake, 1'b1)
        @(posedge ref_clk);
        #1;
        `CHK(cn_wake, 1'b0)
        rd16(8'h70, rd);
        `CHK(rd, 32'h1)
        sleep_mode <= 1'b0;
        // usb pins ignored until transceiver disable is set
        wr16(8'h24, 16'h0008);
        toggle(83);
        rd16(8'h70, rd);
        `CHK(rd, 32'h0)
        wr16(8'h78, 16'h0001);
        toggle(83);
        rd16(8'h70, rd);
        `CHK(rd, 32'h1)
        @(posedge ref_clk);
        #1;
        `CHK(irq, 1'b0)
        print_verdict();
    end
endmodule
`default_nettype wire
